// ---- hw/lec_params.svh ----
`ifndef LEC_PARAMS_SVH
`define LEC_PARAMS_SVH

// Command register pointers on the serial port
`define LEC_OFS_CTRL_A 8'h00
`define LEC_OFS_CTRL_B 8'h01

// Power-on values
`define LEC_RST_CTRL_A 8'h00
`define LEC_RST_CTRL_B 8'h00

// Implemented bits; the rest read as zero
`define LEC_MASK_CTRL_A 8'h3F
`define LEC_MASK_CTRL_B 8'h1F

// Control A fields
`define LEC_A_KEEP2 0
`define LEC_A_LOWST2 1
`define LEC_A_EN2 2
`define LEC_A_KEEP3 3
`define LEC_A_LOWST3 4
`define LEC_A_EN3 5

// Control B fields
`define LEC_B_KEEP4 0
`define LEC_B_LOWST4 1
`define LEC_B_EN4 2
`define LEC_B_LVL_LO 3
`define LEC_B_LVL_HI 4

// Serial port device addresses, base and DDR variants
`define LEC_DEV_ADDR 7'h3C
`define LEC_DEV_ADDR_DDR 7'h3D

`endif

// ---- hw/lec_pkg.sv ----
package lec_pkg;

  typedef enum logic [1:0] {
    LEC_REG_OFF = 2'b01,
    LEC_REG_ON = 2'b10
  } lec_reg_st_type;

  typedef enum logic [8:0] {
    LEC_SP_IDLE = 9'b0_0000_0001,
    LEC_SP_ADDR = 9'b0_0000_0010,
    LEC_SP_AACK = 9'b0_0000_0100,
    LEC_SP_PTR = 9'b0_0000_1000,
    LEC_SP_PACK = 9'b0_0001_0000,
    LEC_SP_WDAT = 9'b0_0010_0000,
    LEC_SP_WACK = 9'b0_0100_0000,
    LEC_SP_RDAT = 9'b0_1000_0000,
    LEC_SP_RACK = 9'b1_0000_0000
  } lec_sp_st_type;

  typedef enum logic [1:0] {
    LEC_VAR_BASE = 2'b01,
    LEC_VAR_DDR = 2'b10
  } lec_variant_type;

endpackage

// ---- hw/lec_ldo_enable_control.sv ----
`timescale 1ns/1ps
`include "lec_params.svh"
// How it works
// - Regulator two runs when control A bit 2 is set, else follows its pin.
// - Regulator three runs when control A bit 5 is set, else follows its pin.
// - Control A bits 0 and 3 keep regulators two and three alive in standby.
// - Control A bits 1 and 4 allow start only while output below 300mV.
// - Control B bit 0 keeps regulator four alive in standby.
// - Control B bit 1 allows regulator four start only below 300mV.
// - Base variant: control B bit 2 enables regulator four, else its pin.
// - DDR variant: control B bit 2 alone switches regulator four.
// - DDR variant: control B bits 4:3 pick 1.2V, 2.5V, 2.8V or 3V.
// - Both control registers power up as all zeros.
// - Reset output goes low while always-on regulator is 8% low.
// - A disabled regulator has its output discharged through 625 ohms.
// - Enable pins are active high, floating pins read as low.
// - Serial-port supply below 1V returns registers to power-on values.
module lec_ldo_enable_control #(
  parameter lec_pkg::lec_variant_type VARIANT = lec_pkg::LEC_VAR_BASE,
  parameter logic [6:0] DEV_ADDR = `LEC_DEV_ADDR
) (
  input wire logic i_sys_clk, // System clock, 100 MHz
  input wire logic i_rst, // Async reset, active high
  input wire logic i_link_clk, // Serial-port logic clock
  input wire logic i_serial_supply_low, // Serial supply under 1V
  input wire logic i_scl, // Serial clock pin
  input wire logic i_sda, // Serial data pin level
  output logic o_sda_out, // Serial data drive value
  output logic o_sda_oe, // Serial data pull-down enable
  input wire logic i_reg_two_enable_pin, // Enable pin, regulator two
  input wire logic i_reg_three_enable_pin, // Enable pin, regulator three
  input wire logic i_reg_four_enable_pin, // Enable pin, regulator four
  input wire logic i_standby, // Device standby request
  input wire logic [2:0] i_out_below_300mv, // Outputs under 300mV, two..four
  input wire logic i_always_on_uv, // Always-on regulator 8% low
  output logic [2:0] o_reg_en, // Regulator run, two..four
  output logic [2:0] o_reg_discharge, // 625 ohm pull-down on, two..four
  output logic [1:0] o_reg4_level, // Regulator four level select
  output logic o_reset_output_n // Reset output, active low
);
  import lec_pkg::*;

  function automatic logic [7:0] reg_read(input logic [7:0] ptr, input logic [7:0] a,
                                          input logic [7:0] b);
    if (ptr == `LEC_OFS_CTRL_A) begin
      reg_read = a & `LEC_MASK_CTRL_A;
    end else if (ptr == `LEC_OFS_CTRL_B) begin
      reg_read = b & `LEC_MASK_CTRL_B;
    end else begin
      reg_read = 8'h00;
    end
  endfunction

  function automatic lec_reg_st_type reg_next(input lec_reg_st_type st, input logic req,
                                              input logic restr, input logic low,
                                              input logic stby, input logic keep);
    case (st)
      LEC_REG_OFF: begin
        reg_next = (req && !stby && (!restr || low)) ? LEC_REG_ON : LEC_REG_OFF;
      end
      LEC_REG_ON: begin
        reg_next = (!req || (stby && !keep)) ? LEC_REG_OFF : LEC_REG_ON;
      end
      default: begin
        reg_next = LEC_REG_OFF;
      end
    endcase
  endfunction

  // Serial-port domain
  logic rst_link;
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, ack_m, ack_s;
  lec_sp_st_type sp_st_r, sp_st_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt;
  logic done_r, done_nxt, rw_r, rw_nxt, oe_r, oe_nxt, nack_r, nack_nxt;
  logic [7:0] ctrl_a_r, ctrl_a_nxt, ctrl_b_r, ctrl_b_nxt;
  logic [7:0] snap_a_r, snap_a_nxt, snap_b_r, snap_b_nxt;
  logic req_r, req_nxt, pend_r, pend_nxt;
  logic ack_r, ack_nxt;
  logic rise, fall, start, stop;

  assign rst_link = i_rst | i_serial_supply_low;

  always_ff @(posedge i_link_clk or posedge rst_link) begin
    if (rst_link) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      ack_m <= 1'b0;
      ack_s <= 1'b0;
    end else begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= i_sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
      ack_m <= ack_r;
      ack_s <= ack_m;
    end
  end

  assign rise = scl_s && !scl_d;
  assign fall = !scl_s && scl_d;
  assign start = scl_s && scl_d && sda_d && !sda_s;
  assign stop = scl_s && scl_d && !sda_d && sda_s;

  always_comb begin
    sp_st_nxt = sp_st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    done_nxt = done_r;
    rw_nxt = rw_r;
    oe_nxt = oe_r;
    nack_nxt = nack_r;
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    snap_a_nxt = snap_a_r;
    snap_b_nxt = snap_b_r;
    req_nxt = req_r;
    pend_nxt = pend_r;
    // Hand the current values to the regulator side when it is free
    if (pend_r && (req_r == ack_s)) begin
      snap_a_nxt = ctrl_a_r;
      snap_b_nxt = ctrl_b_r;
      req_nxt = !req_r;
      pend_nxt = 1'b0;
    end
    if (start) begin
      sp_st_nxt = LEC_SP_ADDR;
      cnt_nxt = 3'd0;
      done_nxt = 1'b0;
      oe_nxt = 1'b0;
    end else if (stop) begin
      sp_st_nxt = LEC_SP_IDLE;
      oe_nxt = 1'b0;
    end else if (rise) begin
      if (sp_st_r == LEC_SP_RACK) begin
        nack_nxt = sda_s;
      end else if (sp_st_r != LEC_SP_IDLE) begin
        sh_nxt = {sh_r[6:0], sda_s};
        cnt_nxt = cnt_r + 3'd1;
        done_nxt = (cnt_r == 3'd7);
      end
    end else if (fall) begin
      case (sp_st_r)
        LEC_SP_ADDR, LEC_SP_PTR, LEC_SP_WDAT: begin
          if (done_r) begin
            done_nxt = 1'b0;
            oe_nxt = 1'b1;
            if (sp_st_r == LEC_SP_ADDR) begin
              rw_nxt = sh_r[0];
              sp_st_nxt = LEC_SP_AACK;
              if (sh_r[7:1] != DEV_ADDR) begin
                oe_nxt = 1'b0;
                sp_st_nxt = LEC_SP_IDLE;
              end
            end else if (sp_st_r == LEC_SP_PTR) begin
              ptr_nxt = sh_r;
              sp_st_nxt = LEC_SP_PACK;
            end else begin
              if (ptr_r == `LEC_OFS_CTRL_A) begin
                ctrl_a_nxt = sh_r & `LEC_MASK_CTRL_A;
              end
              if (ptr_r == `LEC_OFS_CTRL_B) begin
                ctrl_b_nxt = sh_r & `LEC_MASK_CTRL_B;
              end
              pend_nxt = 1'b1;
              sp_st_nxt = LEC_SP_WACK;
            end
          end
        end
        LEC_SP_AACK: begin
          cnt_nxt = 3'd0;
          if (rw_r) begin
            tx_nxt = reg_read(ptr_r, ctrl_a_r, ctrl_b_r);
            oe_nxt = !tx_nxt[7];
            sp_st_nxt = LEC_SP_RDAT;
          end else begin
            oe_nxt = 1'b0;
            sp_st_nxt = LEC_SP_PTR;
          end
        end
        LEC_SP_PACK, LEC_SP_WACK: begin
          oe_nxt = 1'b0;
          cnt_nxt = 3'd0;
          if (sp_st_r == LEC_SP_WACK) begin
            ptr_nxt = ptr_r + 8'h01;
          end
          sp_st_nxt = LEC_SP_WDAT;
        end
        LEC_SP_RDAT: begin
          if (done_r) begin
            done_nxt = 1'b0;
            oe_nxt = 1'b0;
            sp_st_nxt = LEC_SP_RACK;
          end else begin
            tx_nxt = {tx_r[6:0], 1'b0};
            oe_nxt = !tx_nxt[7];
          end
        end
        LEC_SP_RACK: begin
          if (nack_r) begin
            sp_st_nxt = LEC_SP_IDLE;
          end else begin
            ptr_nxt = ptr_r + 8'h01;
            tx_nxt = reg_read(ptr_nxt, ctrl_a_r, ctrl_b_r);
            oe_nxt = !tx_nxt[7];
            cnt_nxt = 3'd0;
            sp_st_nxt = LEC_SP_RDAT;
          end
        end
        default: begin
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_link_clk or posedge rst_link) begin
    if (rst_link) begin
      sp_st_r <= LEC_SP_IDLE;
      cnt_r <= 3'd0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      done_r <= 1'b0;
      rw_r <= 1'b0;
      oe_r <= 1'b0;
      nack_r <= 1'b1;
      ctrl_a_r <= `LEC_RST_CTRL_A;
      ctrl_b_r <= `LEC_RST_CTRL_B;
      snap_a_r <= `LEC_RST_CTRL_A;
      snap_b_r <= `LEC_RST_CTRL_B;
      req_r <= 1'b0;
      pend_r <= 1'b1;
    end else begin
      sp_st_r <= sp_st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      done_r <= done_nxt;
      rw_r <= rw_nxt;
      oe_r <= oe_nxt;
      nack_r <= nack_nxt;
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      snap_a_r <= snap_a_nxt;
      snap_b_r <= snap_b_nxt;
      req_r <= req_nxt;
      pend_r <= pend_nxt;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = oe_r;

  // System domain
  logic req_m, req_s;
  logic [2:0] pin_m, pin_s, low_m, low_s;
  logic stby_m, stby_s, uv_m, uv_s;
  logic [7:0] lin_a_r, lin_a_nxt, lin_b_r, lin_b_nxt;
  lec_reg_st_type st_r [3];
  lec_reg_st_type st_nxt [3];
  logic [2:0] req_v, keep_v, restr_v;
  logic [1:0] lvl_r, lvl_nxt;
  logic rst_out_n_r, rst_out_n_nxt;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
      pin_m <= 3'b000;
      pin_s <= 3'b000;
      low_m <= 3'b000;
      low_s <= 3'b000;
      stby_m <= 1'b0;
      stby_s <= 1'b0;
      uv_m <= 1'b1;
      uv_s <= 1'b1;
    end else begin
      req_m <= req_r;
      req_s <= req_m;
      pin_m <= {i_reg_four_enable_pin, i_reg_three_enable_pin, i_reg_two_enable_pin};
      pin_s <= pin_m;
      low_m <= i_out_below_300mv;
      low_s <= low_m;
      stby_m <= i_standby;
      stby_s <= stby_m;
      uv_m <= i_always_on_uv;
      uv_s <= uv_m;
    end
  end

  always_comb begin
    ack_nxt = ack_r;
    lin_a_nxt = lin_a_r;
    lin_b_nxt = lin_b_r;
    // Snapshot is held stable until the returned toggle is seen
    if (req_s != ack_r) begin
      lin_a_nxt = snap_a_r;
      lin_b_nxt = snap_b_r;
      ack_nxt = req_s;
    end
    req_v[0] = lin_a_r[`LEC_A_EN2] | pin_s[0];
    req_v[1] = lin_a_r[`LEC_A_EN3] | pin_s[1];
    if (VARIANT == LEC_VAR_DDR) begin
      req_v[2] = lin_b_r[`LEC_B_EN4];
      lvl_nxt = lin_b_r[`LEC_B_LVL_HI:`LEC_B_LVL_LO];
    end else begin
      req_v[2] = lin_b_r[`LEC_B_EN4] | pin_s[2];
      lvl_nxt = 2'b00;
    end
    keep_v = {lin_b_r[`LEC_B_KEEP4], lin_a_r[`LEC_A_KEEP3], lin_a_r[`LEC_A_KEEP2]};
    restr_v = {lin_b_r[`LEC_B_LOWST4], lin_a_r[`LEC_A_LOWST3], lin_a_r[`LEC_A_LOWST2]};
    for (int i = 0; i < 3; i++) begin
      st_nxt[i] = reg_next(st_r[i], req_v[i], restr_v[i], low_s[i], stby_s, keep_v[i]);
    end
    rst_out_n_nxt = !uv_s;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_r <= 1'b0;
      lin_a_r <= `LEC_RST_CTRL_A;
      lin_b_r <= `LEC_RST_CTRL_B;
      for (int i = 0; i < 3; i++) begin
        st_r[i] <= LEC_REG_OFF;
      end
      lvl_r <= 2'b00;
      rst_out_n_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      lin_a_r <= lin_a_nxt;
      lin_b_r <= lin_b_nxt;
      for (int i = 0; i < 3; i++) begin
        st_r[i] <= st_nxt[i];
      end
      lvl_r <= lvl_nxt;
      rst_out_n_r <= rst_out_n_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      o_reg_en[i] = st_r[i][1];
      o_reg_discharge[i] = st_r[i][0];
    end
  end
  assign o_reg4_level = lvl_r;
  assign o_reset_output_n = rst_out_n_r;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence seq_two_off_restricted;
    !o_reg_en[0] && lin_a_r[`LEC_A_LOWST2] && !low_s[0];
  endsequence

  chk_reg_two_cmd: assert property (
    lin_a_r[`LEC_A_EN2] && !lin_a_r[`LEC_A_LOWST2] && !stby_s |=> o_reg_en[0])
    else $error("Regulator two not on with command bit set");
  chk_reg_two_pin: assert property (
    !lin_a_r[`LEC_A_EN2] && !pin_s[0] |=> !o_reg_en[0])
    else $error("Regulator two on with pin and bit low");
  chk_reg_three_pin: assert property (
    !lin_a_r[`LEC_A_EN3] && !pin_s[1] |=> !o_reg_en[1])
    else $error("Regulator three on with pin and bit low");
  chk_standby_drop: assert property (
    stby_s && !lin_a_r[`LEC_A_KEEP2] |=> !o_reg_en[0])
    else $error("Regulator two kept in standby without keep-alive");
  chk_keep_alive: assert property (
    o_reg_en[2] && stby_s && lin_b_r[`LEC_B_KEEP4] && req_v[2] |=> o_reg_en[2])
    else $error("Regulator four dropped despite keep-alive");
  chk_restricted_start: assert property (
    seq_two_off_restricted |=> !o_reg_en[0])
    else $error("Regulator two started above 300mV");
  chk_four_cmd_off: assert property (
    (VARIANT == LEC_VAR_DDR) && !lin_b_r[`LEC_B_EN4] |=> !o_reg_en[2])
    else $error("Regulator four on with command bit clear");
  chk_level_sel: assert property (
    (VARIANT == LEC_VAR_DDR) |=> o_reg4_level == $past(lin_b_r[4:3]))
    else $error("Regulator four level does not follow select bits");
  chk_reset_out: assert property (
    uv_s |=> !o_reset_output_n)
    else $error("Reset output high during undervoltage");
  chk_discharge_inv: assert property (
    o_reg_discharge == ~o_reg_en)
    else $error("Discharge not opposite to enable");

endmodule

// ---- dv/lec_host_model.sv ----
`timescale 1ns/1ps
module lec_host_model (
  input wire logic i_clk, // Pacing clock
  input wire logic i_sda, // Data wire level
  output logic o_scl, // Serial clock drive
  output logic o_sda_oe // High pulls data low
);
  initial begin
    o_scl = 1'h1;
    o_sda_oe = 1'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Data only moves while the clock is low
  task automatic put(input logic b);
    o_sda_oe = ~b;
    tick(5);
    o_scl = 1'h1;
    tick(6);
    o_scl = 1'h0;
    tick(1);
  endtask

  task automatic get(output logic b);
    o_sda_oe = 1'h0;
    tick(5);
    o_scl = 1'h1;
    tick(3);
    b = i_sda;
    tick(3);
    o_scl = 1'h0;
    tick(1);
  endtask

  task automatic start();
    o_sda_oe = 1'h1;
    tick(5);
    o_scl = 1'h0;
    tick(1);
  endtask

  task automatic stop();
    o_sda_oe = 1'h1;
    tick(5);
    o_scl = 1'h1;
    tick(5);
    o_sda_oe = 1'h0;
    tick(5);
  endtask

  task automatic send(input logic [7:0] d, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    ok = ok & ~a;
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] d, output logic ok);
    ok = 1'h1;
    start();
    send({dev, 1'h0}, ok);
    send(ptr, ok);
    send(d, ok);
    stop();
  endtask

  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [7:0] d, output logic ok);
    logic b;
    ok = 1'h1;
    start();
    send({dev, 1'h0}, ok);
    send(ptr, ok);
    stop();
    start();
    send({dev, 1'h1}, ok);
    for (int i = 7; i >= 0; i--) begin
      get(b);
      d[i] = b;
    end
    // Refuse further bytes
    put(1'h1);
    stop();
  endtask

  task automatic write_two(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [15:0] d, output logic ok);
    ok = 1'h1;
    start();
    send({dev, 1'h0}, ok);
    send(ptr, ok);
    send(d[15:8], ok);
    send(d[7:0], ok);
    stop();
  endtask

  task automatic read_two(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [15:0] d, output logic ok);
    logic b;
    ok = 1'h1;
    start();
    send({dev, 1'h0}, ok);
    send(ptr, ok);
    stop();
    start();
    send({dev, 1'h1}, ok);
    for (int i = 15; i >= 0; i--) begin
      get(b);
      d[i] = b;
      // Accept the first byte so the pointer advances
      if (i == 8) put(1'h0);
    end
    put(1'h1);
    stop();
  endtask
endmodule

// ---- dv/ldo_enable_control_bench.sv ----
`timescale 1ns/1ps
`include "lec_params.svh"
module ldo_enable_control_bench;
  import lec_pkg::*;
  localparam logic [6:0] DDR_ADDR = `LEC_DEV_ADDR_DDR;
  logic sys_clk = 1'h0;
  logic link_clk = 1'h0;
  logic rst = 1'h1;
  logic ssl = 1'h0;
  logic stby = 1'h0;
  logic uv = 1'h0;
  logic [2:0] pins = 3'h0;
  logic [2:0] below = 3'h7;
  logic scl, m_oe, oe_b, oe_d, rn_b, rn_d, ok;
  logic [2:0] en_b, en_d, dis_b, dis_d, kb;
  logic [1:0] lv_b, lv_d;
  logic [7:0] ra, rb, got;
  wire sda = ~(m_oe | oe_b | oe_d);
  int failures = 0;
  int n_compared = 0;

  always #5 sys_clk = ~sys_clk;
  always #6 link_clk = ~link_clk;

  lec_ldo_enable_control uut (.i_sys_clk(sys_clk), .i_rst(rst), .i_link_clk(link_clk),
    .i_serial_supply_low(ssl), .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(oe_b),
    .i_reg_two_enable_pin(pins[0]), .i_reg_three_enable_pin(pins[1]),
    .i_reg_four_enable_pin(pins[2]), .i_standby(stby), .i_out_below_300mv(below),
    .i_always_on_uv(uv), .o_reg_en(en_b), .o_reg_discharge(dis_b), .o_reg4_level(lv_b),
    .o_reset_output_n(rn_b));
  lec_ldo_enable_control #(.VARIANT(LEC_VAR_DDR), .DEV_ADDR(DDR_ADDR)) uut_ddr (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_link_clk(link_clk),
    .i_serial_supply_low(ssl), .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(oe_d),
    .i_reg_two_enable_pin(pins[0]), .i_reg_three_enable_pin(pins[1]),
    .i_reg_four_enable_pin(pins[2]), .i_standby(stby), .i_out_below_300mv(below),
    .i_always_on_uv(uv), .o_reg_en(en_d), .o_reg_discharge(dis_d), .o_reg4_level(lv_d),
    .o_reset_output_n(rn_d));
  lec_host_model host (.i_clk(sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    host.write_reg(`LEC_DEV_ADDR, ptr, d, ok);
    chk({7'h0, ok}, 8'h01);
    host.write_reg(DDR_ADDR, ptr, d, ok);
    chk({7'h0, ok}, 8'h01);
    if (ptr == `LEC_OFS_CTRL_A) ra = d & `LEC_MASK_CTRL_A;
    if (ptr == `LEC_OFS_CTRL_B) rb = d & `LEC_MASK_CTRL_B;
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [7:0] e);
    host.read_reg(`LEC_DEV_ADDR, ptr, got, ok);
    chk({7'h0, ok}, 8'h01);
    chk(got, e);
    host.read_reg(DDR_ADDR, ptr, got, ok);
    chk({7'h0, ok}, 8'h01);
    chk(got, e);
  endtask

  // Two-byte write burst from control A onwards, both variants
  task automatic wr_two(input logic [15:0] d);
    host.write_two(`LEC_DEV_ADDR, `LEC_OFS_CTRL_A, d, ok);
    chk({7'h0, ok}, 8'h01);
    host.write_two(DDR_ADDR, `LEC_OFS_CTRL_A, d, ok);
    chk({7'h0, ok}, 8'h01);
    ra = d[15:8] & `LEC_MASK_CTRL_A;
    rb = d[7:0] & `LEC_MASK_CTRL_B;
  endtask

  task automatic rd_two();
    logic [15:0] w;
    host.read_two(`LEC_DEV_ADDR, `LEC_OFS_CTRL_A, w, ok);
    chk({7'h0, ok}, 8'h01);
    chk(w[15:8], ra);
    chk(w[7:0], rb);
  endtask

  // Run state outside standby with no start restriction in force
  function automatic logic [2:0] exp_en(input logic ddr);
    return {ddr ? rb[2] : rb[2] | pins[2], ra[5] | pins[1], ra[2] | pins[0]};
  endfunction

  task automatic look(input logic [2:0] eb, input logic [2:0] ed);
    chk({5'h0, en_b}, {5'h0, eb});
    chk({5'h0, dis_b}, {5'h0, ~eb});
    chk({5'h0, en_d}, {5'h0, ed});
    chk({5'h0, dis_d}, {5'h0, ~ed});
    chk({6'h0, lv_d}, {6'h0, rb[4:3]});
    chk({6'h0, lv_b}, 8'h00);
  endtask

  initial begin
    #900_000;
    failures++;
    conclude();
  end

  initial begin
    void'($urandom(97011));
    ra = 8'h00;
    rb = 8'h00;
    step(8);
    rst = 1'h0;
    step(20);
    look(3'h0, 3'h0);
    rd(`LEC_OFS_CTRL_A, 8'h00);
    rd(`LEC_OFS_CTRL_B, 8'h00);
    for (int i = 0; i < 10; i++) begin
      wr(`LEC_OFS_CTRL_A, 8'($urandom));
      wr(`LEC_OFS_CTRL_B, 8'($urandom));
      pins = 3'($urandom);
      step(20);
      look(exp_en(1'h0), exp_en(1'h1));
      rd(`LEC_OFS_CTRL_A, ra);
      rd(`LEC_OFS_CTRL_B, rb);
    end
    pins = 3'h7;
    for (int l = 0; l < 4; l++) begin
      wr(`LEC_OFS_CTRL_B, {3'h0, 2'(l), 3'h0});
      step(10);
      look(exp_en(1'h0), exp_en(1'h1));
    end
    wr(8'h02, 8'h5A);
    rd(8'h02, 8'h00);
    wr_two(16'($urandom));
    step(20);
    look(exp_en(1'h0), exp_en(1'h1));
    rd_two();
    for (int k = 0; k < 8; k++) begin
      kb = 3'(k);
      wr(`LEC_OFS_CTRL_A, {2'h0, 1'h1, 1'h0, kb[1], 1'h1, 1'h0, kb[0]});
      wr(`LEC_OFS_CTRL_B, {5'h0, 1'h1, 1'h0, kb[2]});
      step(20);
      look(3'h7, 3'h7);
      stby = 1'h1;
      step(20);
      look(kb, kb);
      stby = 1'h0;
      step(20);
      look(3'h7, 3'h7);
    end
    pins = 3'h0;
    wr(`LEC_OFS_CTRL_A, 8'h12);
    wr(`LEC_OFS_CTRL_B, 8'h02);
    below = 3'h0;
    step(5);
    wr(`LEC_OFS_CTRL_A, 8'h36);
    wr(`LEC_OFS_CTRL_B, 8'h06);
    step(20);
    look(3'h0, 3'h0);
    below = 3'h7;
    step(20);
    look(3'h7, 3'h7);
    below = 3'h0;
    step(20);
    look(3'h7, 3'h7);
    ssl = 1'h1;
    step(10);
    ssl = 1'h0;
    ra = 8'h00;
    rb = 8'h00;
    step(30);
    look(3'h0, 3'h0);
    rd(`LEC_OFS_CTRL_A, 8'h00);
    rd(`LEC_OFS_CTRL_B, 8'h00);
    uv = 1'h1;
    step(10);
    chk({6'h0, rn_b, rn_d}, 8'h00);
    uv = 1'h0;
    step(10);
    chk({6'h0, rn_b, rn_d}, 8'h03);
    conclude();
  end
endmodule
